//--- rtl/tccu_defs.svh
// Purpose: shared constants of the capture/compare pair and its timer side
// Assumes: 4-bit register address, 8-bit register data
// Notes: offsets are per register; channel n sits at n * stride
`ifndef TCCU_DEFS_SVH
`define TCCU_DEFS_SVH

// register port widths, timer count width and channel count
`define TCCU_ADDR_W 4
`define TCCU_DATA_W 8
`define TCCU_COUNT_W 16
`define TCCU_CHANNELS 2

// per channel register offsets, added to the channel base
`define TCCU_OFS_CTRL 2'h0
`define TCCU_OFS_SRC 2'h1
`define TCCU_OFS_VAL_LO 2'h2
`define TCCU_OFS_VAL_HI 2'h3
// channel base addresses
`define TCCU_ADDR_CH0 4'h0
`define TCCU_ADDR_CH1 4'h4

// shared device registers
`define TCCU_ADDR_IRQ_REQ 4'h8
`define TCCU_ADDR_IRQ_EN 4'h9
`define TCCU_ADDR_ADC_SEL 4'hA

// timer side registers, kept by the host end
`define TCCU_ADDR_TMR_LO 4'hC
`define TCCU_ADDR_TMR_HI 4'hD
`define TCCU_ADDR_TMR_CTL 4'hE

// field positions
`define TCCU_CTRL_MODE_MSB 3
`define TCCU_CTRL_OUT_BIT 5
`define TCCU_ADC_SEL_EN_BIT 0
`define TCCU_ADC_SEL_CH_BIT 1
`define TCCU_TMR_CTL_RUN_BIT 0

// reset values
`define TCCU_RST_BYTE 8'h00
`define TCCU_RST_COUNT 16'h0000
`define TCCU_RST_PSC 4'h0

// prescaler terminal counts
`define TCCU_PSC_LAST4 2'h3
`define TCCU_PSC_LAST16 4'hF

`endif

//--- rtl/tccu_pkg.sv
// Purpose: types shared by both ends of the capture/compare link
// Assumes: mode field is 4 bits, source select 3 bits
// Notes: mode codes not listed here act as channel off
package tccu_pkg;

  // channel_mode_field encodings
  typedef enum logic [3:0] {
    TCCU_MODE_OFF = 4'b0000,
    TCCU_MODE_CMP_TOGGLE = 4'b0001,
    TCCU_MODE_CMP_SET = 4'b0010,
    TCCU_MODE_CMP_CLEAR = 4'b0011,
    TCCU_MODE_CAP_FALL = 4'b0100,
    TCCU_MODE_CAP_RISE = 4'b0101,
    TCCU_MODE_CAP_RISE4 = 4'b0110,
    TCCU_MODE_CAP_RISE16 = 4'b0111,
    TCCU_MODE_CMP_ADC = 4'b1000,
    TCCU_MODE_CMP_SWIRQ = 4'b1001
  } tccu_mode_e;

  // capture_source_select encodings
  typedef enum logic [2:0] {
    TCCU_SRC_PIN = 3'b000,
    TCCU_SRC_CMP1 = 3'b001,
    TCCU_SRC_CMP2 = 3'b010,
    TCCU_SRC_PINCHG = 3'b011,
    TCCU_SRC_LC1 = 3'b100,
    TCCU_SRC_LC2 = 3'b101,
    TCCU_SRC_LC3 = 3'b110,
    TCCU_SRC_LC4 = 3'b111
  } tccu_src_e;

  typedef logic [15:0] tccu_count_t;
  typedef logic [7:0] tccu_byte_t;

endpackage : tccu_pkg

//--- rtl/tccu_link_if.sv
// Purpose: link between the timer/cpu end and the capture/compare end
// Assumes: both ends run on the same clock
// Notes: register strobes are one cycle; read data one cycle later
interface tccu_link_if;
  // register access from the cpu side
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  // live timer count
  tccu_pkg::tccu_count_t timer_count;
  // capture sources
  logic [1:0] remapped_pin_input;
  logic comparator_one_synced;
  logic comparator_two_synced;
  logic pin_change_event;
  logic logic_cell_one_out;
  logic logic_cell_two_out;
  logic logic_cell_three_out;
  logic logic_cell_four_out;

  modport device (
    input reg_addr, reg_wdata, reg_wr, reg_rd, timer_count,
    input remapped_pin_input, comparator_one_synced, comparator_two_synced,
    input pin_change_event, logic_cell_one_out, logic_cell_two_out,
    input logic_cell_three_out, logic_cell_four_out,
    output reg_rdata
  );

  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, timer_count,
    output remapped_pin_input, comparator_one_synced, comparator_two_synced,
    output pin_change_event, logic_cell_one_out, logic_cell_two_out,
    output logic_cell_three_out, logic_cell_four_out,
    input reg_rdata
  );
endinterface : tccu_link_if

//--- rtl/tccu_device.sv
// Purpose: two capture/compare channels working against a 16-bit count
// Assumes: timer count and capture sources arrive on this clock
// Notes: capture and match act one edge after the sampled source/count
// Function
// - capture copies full timer count into value pair
// - mode picks falling, rising, 4th or 16th rising
// - capture sets flag; only software clears it
// - new capture overwrites old value, no overrun
// - 3-bit select picks one of eight sources
// - capture sees actual pin level, even driven
// - mode change may raise a false flag
// - prescaler cleared when off, non-capture, reset
// - prescale change keeps counter; software zeroes control
// - timer runs synchronous to this clock
// - timer counts on instruction clock for capture
// - capture keeps working while timer count frozen
// - compare mode checks value pair against count
// - match toggles, sets, clears, triggers or interrupts
// - match sets flag and optional conversion trigger
// - both channels identical with own registers
// - zero control write forces compare latch low
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "tccu_defs.svh"

module tccu_device (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  tccu_link_if.device LINK,
  output logic [1:0] CHANNEL_OUT_OUT,
  output logic ADC_TRIGGER_OUT,
  output logic [1:0] IRQ_FLAG_OUT
);

  // mode field decoders, unknown codes count as off
  function automatic logic tccu_is_cap(input logic [3:0] m);
    tccu_is_cap = (m == tccu_pkg::TCCU_MODE_CAP_FALL) ||
                  (m == tccu_pkg::TCCU_MODE_CAP_RISE) ||
                  (m == tccu_pkg::TCCU_MODE_CAP_RISE4) ||
                  (m == tccu_pkg::TCCU_MODE_CAP_RISE16);
  endfunction : tccu_is_cap

  function automatic logic tccu_is_cmp(input logic [3:0] m);
    tccu_is_cmp = (m == tccu_pkg::TCCU_MODE_CMP_TOGGLE) ||
                  (m == tccu_pkg::TCCU_MODE_CMP_SET) ||
                  (m == tccu_pkg::TCCU_MODE_CMP_CLEAR) ||
                  (m == tccu_pkg::TCCU_MODE_CMP_ADC) ||
                  (m == tccu_pkg::TCCU_MODE_CMP_SWIRQ);
  endfunction : tccu_is_cmp

  // write hit on one channel register
  function automatic logic tccu_ch_wr(input logic wr, input logic [3:0] a,
                                      input logic [3:0] base,
                                      input logic [1:0] ofs);
    tccu_ch_wr = wr && (a == (base | {2'h0, ofs}));
  endfunction : tccu_ch_wr

  logic [3:0] ctrl_q [2];
  logic [2:0] src_q [2];
  tccu_pkg::tccu_count_t value_q [2];
  logic [1:0] out_q;
  logic [1:0] flag_q;
  logic [1:0] irq_en_q;
  logic [1:0] adc_sel_q;
  logic adc_q;
  logic [7:0] rdata_q;
  logic [1:0] event_set;
  logic [1:0] adc_req;

  // the eight capture sources, pin level already synchronised upstream
  logic [7:0] src_bus [2];
  for (genvar c = 0; c < 2; c++)
  begin : g_src
    assign src_bus[c] = {LINK.logic_cell_four_out, LINK.logic_cell_three_out,
                         LINK.logic_cell_two_out, LINK.logic_cell_one_out,
                         LINK.pin_change_event, LINK.comparator_two_synced,
                         LINK.comparator_one_synced,
                         LINK.remapped_pin_input[c]};
  end

  // identical channel slices, each with its own registers
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    localparam logic [3:0] BASE = (i == 0) ? `TCCU_ADDR_CH0 : `TCCU_ADDR_CH1;
    logic level;
    logic level_q;
    logic [3:0] psc_q;
    logic cap_evt;
    logic match_q;
    logic match_now;
    logic match_rise;
    logic ctrl_wr;
    logic cap_mode;
    logic cmp_mode;

    assign ctrl_wr = tccu_ch_wr(LINK.reg_wr, LINK.reg_addr, BASE,
                                `TCCU_OFS_CTRL);
    assign cap_mode = tccu_is_cap(ctrl_q[i]);
    assign cmp_mode = tccu_is_cmp(ctrl_q[i]);

    // control and source select registers
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
      begin
        ctrl_q[i] <= 4'h0;
        src_q[i] <= 3'h0;
      end
      else
      begin
        if (ctrl_wr)
          ctrl_q[i] <= LINK.reg_wdata[`TCCU_CTRL_MODE_MSB:0];
        if (tccu_ch_wr(LINK.reg_wr, LINK.reg_addr, BASE, `TCCU_OFS_SRC))
          src_q[i] <= LINK.reg_wdata[2:0];
      end
    end

    // source select and edge memory
    assign level = src_bus[i][src_q[i]];
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
        level_q <= 1'b0;
      else
        level_q <= level;
    end

    // prescaler counts rising edges in capture modes only
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
        psc_q <= `TCCU_RST_PSC;
      else if (!cap_mode)
        psc_q <= `TCCU_RST_PSC;
      else if (level && !level_q)
        psc_q <= psc_q + 4'h1;
    end

    // capture event per mode
    always_comb
    begin
      cap_evt = 1'b0;
      unique case (ctrl_q[i])
        tccu_pkg::TCCU_MODE_CAP_FALL: cap_evt = !level && level_q;
        tccu_pkg::TCCU_MODE_CAP_RISE: cap_evt = level && !level_q;
        tccu_pkg::TCCU_MODE_CAP_RISE4:
          cap_evt = level && !level_q &&
                    (psc_q[1:0] == `TCCU_PSC_LAST4);
        tccu_pkg::TCCU_MODE_CAP_RISE16:
          cap_evt = level && !level_q &&
                    (psc_q == `TCCU_PSC_LAST16);
        default: cap_evt = 1'b0;
      endcase
    end

    // value pair: capture beats a software write in the same cycle
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
        value_q[i] <= `TCCU_RST_COUNT;
      else if (cap_evt)
        value_q[i] <= LINK.timer_count;
      else if (tccu_ch_wr(LINK.reg_wr, LINK.reg_addr, BASE, `TCCU_OFS_VAL_LO))
        value_q[i][7:0] <= LINK.reg_wdata;
      else if (tccu_ch_wr(LINK.reg_wr, LINK.reg_addr, BASE, `TCCU_OFS_VAL_HI))
        value_q[i][15:8] <= LINK.reg_wdata;
    end

    // equality detect; one action per match, not per held cycle
    assign match_now = cmp_mode && (value_q[i] == LINK.timer_count);
    assign match_rise = match_now && !match_q;
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
        match_q <= 1'b0;
      else
        match_q <= match_now;
    end

    // compare output latch
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
        out_q[i] <= 1'b0;
      else if (ctrl_wr && (LINK.reg_wdata == `TCCU_RST_BYTE))
        out_q[i] <= 1'b0;
      else if (match_rise)
      begin
        unique case (ctrl_q[i])
          tccu_pkg::TCCU_MODE_CMP_TOGGLE: out_q[i] <= !out_q[i];
          tccu_pkg::TCCU_MODE_CMP_SET: out_q[i] <= 1'b1;
          tccu_pkg::TCCU_MODE_CMP_CLEAR: out_q[i] <= 1'b0;
          default: out_q[i] <= out_q[i];
        endcase
      end
    end

    // events toward the shared flag and trigger logic
    assign event_set[i] = cap_evt || match_rise;
    assign adc_req[i] = match_rise &&
      ((ctrl_q[i] == tccu_pkg::TCCU_MODE_CMP_ADC) ||
       (adc_sel_q[`TCCU_ADC_SEL_EN_BIT] &&
        (adc_sel_q[`TCCU_ADC_SEL_CH_BIT] == 1'(i))));
  end

  // request flags: hardware only sets, a set beats a software clear
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
      flag_q <= 2'h0;
    else if (LINK.reg_wr && (LINK.reg_addr == `TCCU_ADDR_IRQ_REQ))
      flag_q <= LINK.reg_wdata[1:0] | event_set;
    else
      flag_q <= flag_q | event_set;
  end

  // enable and trigger select registers
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      irq_en_q <= 2'h0;
      adc_sel_q <= 2'h0;
    end
    else if (LINK.reg_wr)
    begin
      if (LINK.reg_addr == `TCCU_ADDR_IRQ_EN)
        irq_en_q <= LINK.reg_wdata[1:0];
      if (LINK.reg_addr == `TCCU_ADDR_ADC_SEL)
        adc_sel_q <= LINK.reg_wdata[1:0];
    end
  end

  // conversion trigger, one cycle pulse
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
      adc_q <= 1'b0;
    else
      adc_q <= |adc_req;
  end

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
      rdata_q <= `TCCU_RST_BYTE;
    else if (!LINK.reg_rd)
      rdata_q <= `TCCU_RST_BYTE;
    else if (!LINK.reg_addr[3])
    begin
      unique case (LINK.reg_addr[1:0])
        `TCCU_OFS_CTRL:
          rdata_q <= {2'h0, out_q[LINK.reg_addr[2]], 1'b0,
                      ctrl_q[LINK.reg_addr[2]]};
        `TCCU_OFS_SRC: rdata_q <= {5'h00, src_q[LINK.reg_addr[2]]};
        `TCCU_OFS_VAL_LO: rdata_q <= value_q[LINK.reg_addr[2]][7:0];
        `TCCU_OFS_VAL_HI: rdata_q <= value_q[LINK.reg_addr[2]][15:8];
      endcase
    end
    else if (LINK.reg_addr == `TCCU_ADDR_IRQ_REQ)
      rdata_q <= {6'h00, flag_q};
    else if (LINK.reg_addr == `TCCU_ADDR_IRQ_EN)
      rdata_q <= {6'h00, irq_en_q};
    else if (LINK.reg_addr == `TCCU_ADDR_ADC_SEL)
      rdata_q <= {6'h00, adc_sel_q};
    else
      rdata_q <= `TCCU_RST_BYTE; // unmapped and timer addresses read zero
  end

  assign LINK.reg_rdata = rdata_q;
  assign CHANNEL_OUT_OUT = out_q;
  assign ADC_TRIGGER_OUT = adc_q;
  assign IRQ_FLAG_OUT = flag_q;

endmodule : tccu_device

//--- rtl/tccu_host.sv
// Purpose: timer and cpu side of the capture/compare link
// Assumes: software port strobes are one cycle and never together
// Notes: timer counts once per clock while running and awake
`include "tccu_defs.svh"

module tccu_host (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  tccu_link_if.host LINK,
  input wire logic [3:0] SW_ADDR_IN,
  input wire logic [7:0] SW_WDATA_IN,
  input wire logic SW_WR_IN,
  input wire logic SW_RD_IN,
  output logic [7:0] SW_RDATA_OUT,
  input wire logic SLEEP_IN,
  input wire logic [1:0] PIN_IN,
  input wire logic COMP_ONE_IN,
  input wire logic COMP_TWO_IN,
  input wire logic PIN_CHANGE_IN,
  input wire logic [3:0] LOGIC_CELL_IN
);

  tccu_pkg::tccu_count_t count_q;
  logic run_q;
  logic [7:0] rdata_q;
  logic [2:0] sync_q [2];
  logic [1:0] pin_q;

  // pin levels: three stages, a change taken when stages two and three agree
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    always_ff @(posedge REF_CLK_IN)
    begin
      if (!NRST_IN)
      begin
        sync_q[p] <= 3'h0;
        pin_q[p] <= 1'b0;
      end
      else
      begin
        sync_q[p] <= {sync_q[p][1:0], PIN_IN[p]};
        if (sync_q[p][1] == sync_q[p][2])
          pin_q[p] <= sync_q[p][2];
      end
    end
  end

  // timer: instruction clock mode, frozen in sleep, resumes counting on wake
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
      count_q <= `TCCU_RST_COUNT;
    else if (SW_WR_IN && (SW_ADDR_IN == `TCCU_ADDR_TMR_LO))
      count_q[7:0] <= SW_WDATA_IN;
    else if (SW_WR_IN && (SW_ADDR_IN == `TCCU_ADDR_TMR_HI))
      count_q[15:8] <= SW_WDATA_IN;
    else if (run_q && !SLEEP_IN)
      count_q <= count_q + 16'h0001;
  end

  // timer control register
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
      run_q <= 1'b0;
    else if (SW_WR_IN && (SW_ADDR_IN == `TCCU_ADDR_TMR_CTL))
      run_q <= SW_WDATA_IN[`TCCU_TMR_CTL_RUN_BIT];
  end

  // read data of the timer registers
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
      rdata_q <= `TCCU_RST_BYTE;
    else if (SW_RD_IN && (SW_ADDR_IN == `TCCU_ADDR_TMR_LO))
      rdata_q <= count_q[7:0];
    else if (SW_RD_IN && (SW_ADDR_IN == `TCCU_ADDR_TMR_HI))
      rdata_q <= count_q[15:8];
    else if (SW_RD_IN && (SW_ADDR_IN == `TCCU_ADDR_TMR_CTL))
      rdata_q <= {7'h00, run_q};
    else
      rdata_q <= `TCCU_RST_BYTE;
  end

  // register access passes straight to the channels; both answers merge
  assign LINK.reg_addr = SW_ADDR_IN;
  assign LINK.reg_wdata = SW_WDATA_IN;
  assign LINK.reg_wr = SW_WR_IN;
  assign LINK.reg_rd = SW_RD_IN;
  assign SW_RDATA_OUT = rdata_q | LINK.reg_rdata;

  // count and capture sources toward the channels
  assign LINK.timer_count = count_q;
  assign LINK.remapped_pin_input = pin_q;
  assign LINK.comparator_one_synced = COMP_ONE_IN;
  assign LINK.comparator_two_synced = COMP_TWO_IN;
  assign LINK.pin_change_event = PIN_CHANGE_IN;
  assign LINK.logic_cell_one_out = LOGIC_CELL_IN[0];
  assign LINK.logic_cell_two_out = LOGIC_CELL_IN[1];
  assign LINK.logic_cell_three_out = LOGIC_CELL_IN[2];
  assign LINK.logic_cell_four_out = LOGIC_CELL_IN[3];

endmodule : tccu_host

//--- tb/tccu_sva.sv
// Purpose: assertions on the capture/compare link and device outputs
// Assumes: one clock, synchronous active-low reset
// Notes: helper flops mirror the settings written over the link
module tccu_sva (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [1:0] remapped_pin_input,
  input wire logic [1:0] CHANNEL_OUT_OUT,
  input wire logic ADC_TRIGGER_OUT,
  input wire logic [1:0] IRQ_FLAG_OUT
);
  logic [3:0] mode0_q;
  logic [3:0] mode1_q;
  logic [2:0] src0_q;
  logic sel_q;
  logic wr_irq;
  logic wr_ctl0;

  // decode of the writes that matter here
  assign wr_irq = reg_wr && (reg_addr == 4'h8);
  assign wr_ctl0 = reg_wr && (reg_addr == 4'h0);

  // mirror of modes, channel 0 source and the trigger enable
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      mode0_q <= 4'h0;
      mode1_q <= 4'h0;
      src0_q <= 3'h0;
      sel_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        4'h0: mode0_q <= reg_wdata[3:0];
        4'h1: src0_q <= reg_wdata[2:0];
        4'h4: mode1_q <= reg_wdata[3:0];
        4'hA: sel_q <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  // control write of exactly zero on channel 0
  sequence s_ctl0_zero;
    wr_ctl0 && reg_wdata == 8'h00;
  endsequence

  // qualifying pin edge for the plain rising or falling capture modes
  sequence s_pin0_edge;
    $past(NRST_IN) && src0_q == 3'h0
    && ((mode0_q == tccu_pkg::TCCU_MODE_CAP_RISE
         && $rose(remapped_pin_input[0]))
    || (mode0_q == tccu_pkg::TCCU_MODE_CAP_FALL
        && $fell(remapped_pin_input[0])));
  endsequence

  a_flag_sticky: assert property (
    $past(NRST_IN) && !$past(wr_irq)
    |-> (~IRQ_FLAG_OUT & $past(IRQ_FLAG_OUT)) == 2'h0)
    else $error("flag dropped without a software write");
  a_cap_flag: assert property (
    s_pin0_edge |=> IRQ_FLAG_OUT[0])
    else $error("pin edge gave no capture flag");
  a_off_silent: assert property (
    $past(NRST_IN) && !$past(wr_irq) && $rose(IRQ_FLAG_OUT[0])
    |-> $past(mode0_q) inside {[4'h1:4'h9]})
    else $error("flag raised while channel off");
  a_zero_clear: assert property (
    s_ctl0_zero |=> !CHANNEL_OUT_OUT[0])
    else $error("zero control write left latch high");
  a_latch_hold: assert property (
    $past(NRST_IN) && !$past(wr_ctl0) && !($past(mode0_q) inside {[4'h1:4'h3]})
    |-> $stable(CHANNEL_OUT_OUT[0]))
    else $error("latch moved outside output modes");
  a_set_nofall: assert property (
    $past(NRST_IN) && !$past(wr_ctl0) && $past(mode0_q) == 4'h2
    |-> !$fell(CHANNEL_OUT_OUT[0]))
    else $error("latch fell in set mode");
  a_match_flag: assert property (
    $past(NRST_IN) && !$past(wr_ctl0) && $changed(CHANNEL_OUT_OUT[0])
    |-> IRQ_FLAG_OUT[0])
    else $error("latch action without flag");
  a_trig_flag: assert property (
    ADC_TRIGGER_OUT |-> IRQ_FLAG_OUT != 2'h0)
    else $error("trigger without flag");
  a_trig_cause: assert property (
    $past(NRST_IN) && ADC_TRIGGER_OUT
    |-> $past(mode0_q == 4'h8 || mode1_q == 4'h8 || sel_q))
    else $error("trigger while not selected");
endmodule : tccu_sva

//--- tb/tb.sv
// Purpose: self-checking bench for both ends joined by the link
// Assumes: read data stand in the cycle after the read strobe
// Notes: the driver queues every expected read; a monitor compares
`define CHK(nm, e, a) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, a); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [7:0] v;} tccu_note_s;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic sleep = 1'b0;
  logic [7:0] src = 8'h00; // bit k drives capture source code k
  logic [1:0] ch_out;
  logic adc_trig;
  logic [1:0] irq_flag;
  logic rd_d = 1'b0;
  logic [15:0] v;
  logic [7:0] lat;
  logic [7:0] exp_out; // expected {latches, flags} at a trigger pulse
  logic [3:0] cmp_mode [5] = '{4'h1, 4'h3, 4'h2, 4'h8, 4'h9};
  tccu_note_s notes[$];
  tccu_note_s n;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 98;

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  tccu_link_if link ();
  tccu_host tccu_host_i (
    .REF_CLK_IN(ref_clk),
    .NRST_IN(nrst),
    .LINK(link.host),
    .SW_ADDR_IN(sw_addr),
    .SW_WDATA_IN(sw_wdata),
    .SW_WR_IN(sw_wr),
    .SW_RD_IN(sw_rd),
    .SW_RDATA_OUT(sw_rdata),
    .SLEEP_IN(sleep),
    .PIN_IN({src[0], src[0]}),
    .COMP_ONE_IN(src[1]),
    .COMP_TWO_IN(src[2]),
    .PIN_CHANGE_IN(src[3]),
    .LOGIC_CELL_IN(src[7:4])
  );
  tccu_device tccu_device_i (
    .REF_CLK_IN(ref_clk),
    .NRST_IN(nrst),
    .LINK(link.device),
    .CHANNEL_OUT_OUT(ch_out),
    .ADC_TRIGGER_OUT(adc_trig),
    .IRQ_FLAG_OUT(irq_flag)
  );
  tccu_sva tccu_sva_i (
    .REF_CLK_IN(ref_clk),
    .NRST_IN(nrst),
    .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr),
    .remapped_pin_input(link.remapped_pin_input),
    .CHANNEL_OUT_OUT(ch_out),
    .ADC_TRIGGER_OUT(adc_trig),
    .IRQ_FLAG_OUT(irq_flag)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // one strobe cycle, then a quiet cycle so strobes never double up
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
    notes.push_back('{s, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : idle

  // n rising edges on source k, long enough for the pin synchroniser
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      src[k] <= 1'b1;
      idle(6);
      src[k] <= 1'b0;
      idle(6);
    end
  endtask : pulse

  // compare read data with the oldest note; also the hang limit
  always @(posedge ref_clk)
  begin
    rd_d <= sw_rd;
    cycles++;
    if (rd_d)
    begin
      n = notes.pop_front();
      `CHK(n.nm, n.v, sw_rdata)
    end
    // each trigger pulse takes its own note: latches and flags beside it
    if (adc_trig)
    begin
      n = notes.pop_front();
      `CHK(n.nm, n.v, {4'h0, ch_out, irq_flag})
    end
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  // main sequence: captures while asleep, prescaler, then compares
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    sleep <= 1'b1;
    wr(4'hE, 8'h01);
    wr(4'h0, 8'h05);
    for (int k = 0; k < 8; k++)
    begin
      v = 16'($random(seed));
      wr(4'h1, 8'(k));
      wr(4'hC, v[7:0]);
      wr(4'hD, v[15:8]);
      wr(4'h8, 8'h00);
      pulse(k, 1);
      rd(4'h2, v[7:0], "capture low");
      rd(4'h3, v[15:8], "capture high");
      rd(4'h8, 8'h01, "capture flag");
    end
    wr(4'hD, 8'h5A);
    pulse(7, 1);
    rd(4'h3, 8'h5A, "overwrite");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h04);
    wr(4'h8, 8'h00);
    src[0] <= 1'b1;
    idle(6);
    rd(4'h8, 8'h00, "no fall yet");
    src[0] <= 1'b0;
    idle(6);
    rd(4'h8, 8'h01, "fall capture");
    wr(4'h0, 8'h0C);
    wr(4'h8, 8'h00);
    pulse(0, 2);
    rd(4'h8, 8'h00, "unknown code");
    wr(4'h1, 8'h01);
    for (int m = 6; m < 8; m++)
    begin
      wr(4'h0, 8'h00);
      wr(4'h0, 8'(m));
      wr(4'h8, 8'h00);
      pulse(1, (m == 6) ? 3 : 15);
      rd(4'h8, 8'h00, "prescale early");
      pulse(1, 1);
      rd(4'h8, 8'h01, "prescale due");
    end
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h06);
    pulse(1, 2);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h06);
    wr(4'h8, 8'h00);
    pulse(1, 2);
    rd(4'h8, 8'h00, "prescale cleared");
    wr(4'h0, 8'h07);
    pulse(1, 1);
    wr(4'h0, 8'h06);
    wr(4'h8, 8'h00);
    pulse(1, 1);
    rd(4'h8, 8'h01, "prescale kept");
    wr(4'h0, 8'h00);
    sleep <= 1'b0;
    for (int ch = 0; ch < 2; ch++)
    begin
      wr(4'hA, {6'h00, ch[0], 1'b1});
      lat = 8'h00;
      foreach (cmp_mode[i])
      begin
        v = 16'($random(seed));
        wr(4'hE, 8'h00);
        // park on an unknown code so half-loaded bytes cannot match
        wr(4'(ch * 4), 8'h0C);
        wr(4'(ch * 4 + 2), v[7:0]);
        wr(4'(ch * 4 + 3), v[15:8]);
        v = v - 16'h0004;
        wr(4'hC, v[7:0]);
        wr(4'hD, v[15:8]);
        wr(4'h8, 8'h00);
        wr(4'(ch * 4), {4'h0, cmp_mode[i]});
        case (cmp_mode[i])
          4'h1: lat = lat ^ 8'h20;
          4'h2: lat = 8'h20;
          4'h3: lat = 8'h00;
          default: lat = lat;
        endcase
        exp_out = {4'h0, 2'(lat[5]) << ch, 2'(1 << ch)};
        notes.push_back('{"trigger outputs", exp_out});
        wr(4'hE, 8'h01);
        idle(8);
        rd(4'(ch * 4), lat | {4'h0, cmp_mode[i]}, "latch");
        rd(4'h8, 8'(1 << ch), "match flag");
      end
      wr(4'(ch * 4), 8'h00);
      rd(4'(ch * 4), 8'h00, "latch cleared");
    end
    idle(2);
    `CHK("notes left", 8'h00, 8'(notes.size()))
    print_verdict();
  end
endmodule : tb
